// [verilog/crad_pkg.sv]
package crad_pkg;
    // command byte layout
    localparam int CMD_BITS     = 8;
    localparam int CLASS_POS    = 7;           // command_class_bit
    localparam int CHAN_MSB     = 6;           // channel_code_msb
    localparam int CHAN_LSB     = 4;           // channel_code_lsb
    localparam int DIR_POS      = 3;           // direction flag
    localparam int RSEL_MSB     = 2;
    localparam int RSEL_LSB     = 0;
    localparam logic [2:0] RSEL_OFFSET = 3'h1;
    localparam logic [2:0] RSEL_GAIN   = 3'h2;
    localparam logic       DIR_READ    = 1'h1; // zero means write
    localparam logic       CLASS_REG   = 1'h0; // one means conversion
    // calibration word
    localparam int WORD_BITS    = 24;
    localparam int CNT_BITS     = 5;
    // reset values
    localparam logic [WORD_BITS-1:0] SHREG_RST = 24'h000000;
    localparam logic [CNT_BITS-1:0]  CNT_RST   = 5'h00;
    localparam logic [2:0]           CHAN_RST  = 3'h0;
    localparam logic [7:0]           CMD_RST   = 8'h00;

    typedef enum logic [2:0] {
        ST_CMD = 3'h1,
        ST_WR  = 3'h2,
        ST_RD  = 3'h4
    } crad_state_type;
endpackage : crad_pkg

// [verilog/crad_sync.sv]
`timescale 1ns/1ps
module crad_sync #(
    parameter int W = 3
) (
    input  wire logic         mclk, // system clock
    input  wire logic         srst, // synchronous reset, active high
    input  wire logic [W-1:0] din,  // asynchronous pin levels
    output logic      [W-1:0] dout  // levels in the mclk domain
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } crad_sync_type;

    crad_sync_type s_q;
    crad_sync_type s_d;

    ////////////////////////////////////////////////////////////////////////////
    // two stages; the first is read by the second only
    always_comb begin
        s_d      = s_q;
        s_d.meta = din;
        s_d.stab = s_q.meta;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.stab;
endmodule : crad_sync

// [verilog/crad_top.sv]
`timescale 1ns/1ps
// Functional notes
// - class 0, select 001: offset register access; channel bits 6-4, direction bit 3.
// - class 0, select 010: gain register access, same channel and direction fields.
// - direction flag decides whether the data phase writes or returns the register.
// - offset channel codes 0..7 pick registers 1..8, only those the variant has.
// - gain channel codes pick gain registers 1.., only those the variant has.
// - class bit must be zero; one marks a conversion command passed elsewhere.
// - direction 0 requests a write, 1 requests a read.
module crad_top
    import crad_pkg::*;
#(
    parameter int NUM_CHANNELS = 8
) (
    input  wire logic                 mclk,         // 100 MHz system clock
    input  wire logic                 srst,         // synchronous reset, active high
    input  wire logic                 sclk,         // serial clock from host
    input  wire logic                 cs_n,         // port select from host, active low
    input  wire logic                 sdi,          // serial data from host
    output logic                      sdo,          // serial data to host
    output logic                      cal_sel_gain, // 1 gain, 0 offset register
    output logic [2:0]                cal_sel_chan, // selected channel register
    output logic                      cal_wr_stb,   // one-cycle write pulse
    output logic [WORD_BITS-1:0]      cal_wr_data,  // write word, valid with strobe
    output logic                      cal_rd_req,   // one-cycle read request
    input  wire logic [WORD_BITS-1:0] cal_rd_data,  // read word, valid cycle after request
    output logic                      cmd_pass_stb, // byte not for this decoder
    output logic                      cmd_rej_stb,  // access to absent register
    output logic [CMD_BITS-1:0]       cmd_byte      // last command byte received
);
    typedef struct packed {
        crad_state_type       st;
        logic [CNT_BITS-1:0]  bits;
        logic [WORD_BITS-1:0] shreg;
        logic                 sclk_prev;
        logic                 sdo;
        logic                 wr_stb;
        logic                 rd_req;
        logic                 ld;
        logic                 gain;
        logic [2:0]           chan;
        logic                 pass;
        logic                 rej;
        logic [CMD_BITS-1:0]  cmd;
    } crad_top_state_type;

    localparam crad_top_state_type S_RST = '{st: ST_CMD, bits: CNT_RST, shreg: SHREG_RST,
        sclk_prev: 1'b0, sdo: 1'b0, wr_stb: 1'b0, rd_req: 1'b0, ld: 1'b0, gain: 1'b0,
        chan: CHAN_RST, pass: 1'b0, rej: 1'b0, cmd: CMD_RST};

    crad_top_state_type s_q;
    crad_top_state_type s_d;
    logic [2:0]         pin_s;
    logic               sclk_s;
    logic               cs_n_s;
    logic               sdi_s;
    logic               rise;
    logic               fall;
    logic [7:0]         cmd_w;
    logic               cmd_done;
    logic               is_cal;
    logic               chan_ok;

    ////////////////////////////////////////////////////////////////////////////
    // pins come from the host clock domain
    crad_sync #(
        .W (3)
    ) u_sync (
        .mclk (mclk),
        .srst (srst),
        .din  ({sclk, cs_n, sdi}),
        .dout (pin_s)
    );

    assign sclk_s = pin_s[2];
    assign cs_n_s = pin_s[1];
    assign sdi_s  = pin_s[0];

    // edges seen on the synchronised clock; host sclk must be slow vs mclk
    assign rise     = sclk_s & ~s_q.sclk_prev;
    assign fall     = ~sclk_s & s_q.sclk_prev;
    assign cmd_w    = {s_q.shreg[CMD_BITS-2:0], sdi_s};
    assign cmd_done = (s_q.st == ST_CMD) && !cs_n_s && rise && (s_q.bits == CNT_BITS'(CMD_BITS - 1));
    assign is_cal   = (cmd_w[CLASS_POS] == CLASS_REG) &&
                      ((cmd_w[RSEL_MSB:RSEL_LSB] == RSEL_OFFSET) ||
                       (cmd_w[RSEL_MSB:RSEL_LSB] == RSEL_GAIN));
    assign chan_ok  = int'(cmd_w[CHAN_MSB:CHAN_LSB]) < NUM_CHANNELS;

    ////////////////////////////////////////////////////////////////////////////
    // command, write and read phases
    always_comb begin
        s_d           = s_q;
        s_d.sclk_prev = sclk_s;
        s_d.wr_stb    = 1'b0;
        s_d.rd_req    = 1'b0;
        s_d.ld        = s_q.rd_req; // storage answers one cycle after the request
        s_d.pass      = 1'b0;
        s_d.rej       = 1'b0;
        if (cs_n_s) begin
            // deselect abandons any partial byte or word
            s_d.st   = ST_CMD;
            s_d.bits = CNT_RST;
        end else begin
            case (s_q.st)
                ST_CMD: begin
                    if (rise) begin
                        s_d.shreg = {s_q.shreg[WORD_BITS-2:0], sdi_s};
                        if (cmd_done) begin
                            s_d.bits = CNT_RST;
                            s_d.cmd  = cmd_w;
                            if (is_cal && chan_ok) begin
                                s_d.gain = (cmd_w[RSEL_MSB:RSEL_LSB] == RSEL_GAIN);
                                s_d.chan = cmd_w[CHAN_MSB:CHAN_LSB];
                                if (cmd_w[DIR_POS] == DIR_READ) begin
                                    s_d.st     = ST_RD;
                                    s_d.rd_req = 1'b1;
                                end else begin
                                    s_d.st = ST_WR;
                                end
                            end else if (is_cal) begin
                                s_d.rej = 1'b1;  // register absent on this variant
                            end else begin
                                s_d.pass = 1'b1; // conversion or other register command
                            end
                        end else begin
                            s_d.bits = s_q.bits + CNT_BITS'(1);
                        end
                    end
                end
                ST_WR: begin
                    if (rise) begin
                        s_d.shreg = {s_q.shreg[WORD_BITS-2:0], sdi_s};
                        if (s_q.bits == CNT_BITS'(WORD_BITS - 1)) begin
                            s_d.wr_stb = 1'b1;
                            s_d.st     = ST_CMD;
                            s_d.bits   = CNT_RST;
                        end else begin
                            s_d.bits = s_q.bits + CNT_BITS'(1);
                        end
                    end
                end
                ST_RD: begin
                    if (s_q.ld) begin
                        s_d.shreg = cal_rd_data;
                        s_d.sdo   = cal_rd_data[WORD_BITS-1];
                    end else if (rise) begin
                        if (s_q.bits == CNT_BITS'(WORD_BITS - 1)) begin
                            s_d.st   = ST_CMD;
                            s_d.bits = CNT_RST;
                        end else begin
                            s_d.bits = s_q.bits + CNT_BITS'(1);
                        end
                    end else if (fall) begin
                        // host samples on rise; the fall closing the command byte must re-present the msb
                        s_d.shreg = {s_q.shreg[WORD_BITS-2:0], 1'b0};
                        s_d.sdo   = s_q.shreg[WORD_BITS-1];
                    end
                end
                default: begin
                    s_d.st   = ST_CMD;
                    s_d.bits = CNT_RST;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= S_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign sdo          = s_q.sdo;
    assign cal_sel_gain = s_q.gain;
    assign cal_sel_chan = s_q.chan;
    assign cal_wr_stb   = s_q.wr_stb;
    assign cal_wr_data  = s_q.shreg;
    assign cal_rd_req   = s_q.rd_req;
    assign cmd_pass_stb = s_q.pass;
    assign cmd_rej_stb  = s_q.rej;
    assign cmd_byte     = s_q.cmd;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence offset_cmd_s;
        cmd_done && is_cal && chan_ok && (cmd_w[RSEL_MSB:RSEL_LSB] == RSEL_OFFSET);
    endsequence

    sequence gain_cmd_s;
        cmd_done && is_cal && chan_ok && (cmd_w[RSEL_MSB:RSEL_LSB] == RSEL_GAIN);
    endsequence

    sequence read_load_s;
        s_q.ld ##1 (sdo == $past(cal_rd_data[WORD_BITS-1]));
    endsequence

    offset_sel_a: assert property (@(posedge mclk) disable iff (srst)
        offset_cmd_s |=> !cal_sel_gain && (cal_sel_chan == $past(cmd_w[CHAN_MSB:CHAN_LSB])))
        else $error("offset command did not select offset register");
    gain_sel_a: assert property (@(posedge mclk) disable iff (srst)
        gain_cmd_s |=> cal_sel_gain && (cal_sel_chan == $past(cmd_w[CHAN_MSB:CHAN_LSB])))
        else $error("gain command did not select gain register");
    read_dir_a: assert property (@(posedge mclk) disable iff (srst)
        (cmd_done && is_cal && chan_ok && cmd_w[DIR_POS]) |=> cal_rd_req && (s_q.st == ST_RD))
        else $error("read direction did not start read phase");
    write_dir_a: assert property (@(posedge mclk) disable iff (srst)
        (cmd_done && is_cal && chan_ok && !cmd_w[DIR_POS]) |=> !cal_rd_req && (s_q.st == ST_WR))
        else $error("write direction did not start write phase");
    offset_range_a: assert property (@(posedge mclk) disable iff (srst)
        (cal_wr_stb || cal_rd_req) && !cal_sel_gain |-> int'(cal_sel_chan) < NUM_CHANNELS)
        else $error("absent offset register accessed");
    gain_range_a: assert property (@(posedge mclk) disable iff (srst)
        (cmd_done && is_cal && !chan_ok) |=> cmd_rej_stb && !cal_rd_req && (s_q.st == ST_CMD))
        else $error("absent register access not refused");
    class_pass_a: assert property (@(posedge mclk) disable iff (srst)
        (cmd_done && cmd_w[CLASS_POS]) |=> cmd_pass_stb && (s_q.st == ST_CMD))
        else $error("conversion class byte not passed on");
    word_len_a: assert property (@(posedge mclk) disable iff (srst)
        cal_wr_stb |-> $past(s_q.st == ST_WR && s_q.bits == CNT_BITS'(WORD_BITS - 1) && rise))
        else $error("write strobe not after 24th bit");
    read_load_a: assert property (@(posedge mclk) disable iff (srst)
        cal_rd_req |=> read_load_s)
        else $error("read word msb not driven on sdo");
endmodule : crad_top

// [verif/crad_host.sv]
`timescale 1ns/1ps
module crad_host (
    input  wire logic mclk, // system clock, paces the host
    output logic      sclk, // serial clock, stands low outside frames
    output logic      cs_n, // port select, active low
    output logic      sdi,  // data to device
    input  wire logic sdo   // data from device
);
    localparam int HALF = 8; // mclk cycles per clock phase, above the minimum of 3
    ////////////////////////////////////////////////////////////////////////
    // idle levels at time zero
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // moves always land just after an mclk rise, never on it
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wait_cyc
    // one frame: command byte, then nbits of the word, msb first; reads on rise
    task automatic frame(input logic [7:0] cmd, input logic [23:0] wdata, input int nbits,
                         output logic [23:0] rdata);
        logic [31:0] bits;
        bits  = {cmd, wdata};
        rdata = 24'h000000;
        wait_cyc(1);
        cs_n = 1'b0;
        for (int i = 0; i < 8 + nbits; i++) begin
            sdi = bits[31-i];
            wait_cyc(HALF);
            sclk = 1'b1;
            if (i >= 8) rdata = {rdata[22:0], sdo};
            wait_cyc(HALF);
            sclk = 1'b0;
        end
        wait_cyc(HALF);
        cs_n = 1'b1;
        sdi  = ~sdi; // a released line must not look like the last bit
    endtask : frame
endmodule : crad_host

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import crad_pkg::*;
    logic        mclk, srst, sclk, cs_n, sdi, sdo, sel_gain, wr_stb, rd_req, pass_stb, rej_stb;
    logic        wr_small, rd_small, rej_small;
    logic [2:0]  sel_chan;
    logic [7:0]  cmd_byte;
    logic [23:0] wr_data, rd_data, last_wr, rdata;
    logic [23:0] regs [16];
    int          failures, samples_checked, wr_cnt, rd_cnt, pass_cnt, rej_cnt;
    int          rej_small_cnt, acc_small_cnt;
    ////////////////////////////////////////////////////////////////////////
    crad_host u_host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
    crad_top #(.NUM_CHANNELS(8)) u_dut (
        .mclk(mclk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .cal_sel_gain(sel_gain), .cal_sel_chan(sel_chan), .cal_wr_stb(wr_stb),
        .cal_wr_data(wr_data), .cal_rd_req(rd_req), .cal_rd_data(rd_data),
        .cmd_pass_stb(pass_stb), .cmd_rej_stb(rej_stb), .cmd_byte(cmd_byte));
    // two-channel variant on the same pins, to reach the refusal path
    crad_top #(.NUM_CHANNELS(2)) u_dut_small (
        .mclk(mclk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(),
        .cal_sel_gain(), .cal_sel_chan(), .cal_wr_stb(wr_small),
        .cal_wr_data(), .cal_rd_req(rd_small), .cal_rd_data(24'h000000),
        .cmd_pass_stb(), .cmd_rej_stb(rej_small), .cmd_byte());
    ////////////////////////////////////////////////////////////////////////
    // clock, and register storage beside the decoder
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    initial begin
        for (int i = 0; i < 16; i++) regs[i] = 24'h000000;
        rd_data = 24'h000000;
    end
    always @(posedge mclk) begin
        if (wr_stb) begin
            wr_cnt++;
            last_wr = wr_data;
            regs[{sel_gain, sel_chan}] = wr_data;
        end
        if (rd_req) rd_cnt++;
        if (pass_stb) pass_cnt++;
        if (rej_stb) rej_cnt++;
        if (rej_small) rej_small_cnt++;
        if (wr_small || rd_small) acc_small_cnt++;
        #1;
        rd_data = regs[{sel_gain, sel_chan}]; // settled well before it is sampled
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] cal_cmd(input logic gain, input logic [2:0] ch, input logic rd);
        return {1'b0, ch, rd, gain ? 3'h2 : 3'h1};
    endfunction : cal_cmd
    // every channel: write a word, then read it back
    task automatic t_write_read(input logic gain);
        logic [23:0] w;
        int n;
        for (int ch = 0; ch < 8; ch++) begin
            w = {gain ? 8'hA5 : 8'h5A, 13'h0ACE, ch[2:0]};
            n = wr_cnt;
            u_host.frame(cal_cmd(gain, ch[2:0], 1'b0), w, 24, rdata);
            chk(wr_cnt, n + 1);
            chk(last_wr, w);
            chk(sel_gain, gain);
            chk(sel_chan, ch);
            chk(cmd_byte, cal_cmd(gain, ch[2:0], 1'b0));
            n = rd_cnt;
            u_host.frame(cal_cmd(gain, ch[2:0], 1'b1), 24'h000000, 24, rdata);
            chk(rd_cnt, n + 1);
            chk(rdata, w);
        end
    endtask : t_write_read
    // conversion class and non-calibration codes are not ours
    task automatic t_pass;
        logic [7:0] codes [7] = '{8'h81, 8'hF8, 8'h00, 8'h13, 8'h15, 8'h16, 8'h17};
        int n;
        for (int i = 0; i < 7; i++) begin
            n = pass_cnt;
            u_host.frame(codes[i], 24'h000000, 0, rdata);
            chk(pass_cnt, n + 1);
            chk(cmd_byte, codes[i]);
        end
    endtask : t_pass
    // a word cut short by deselect writes nothing; the next frame still works
    task automatic t_abort;
        int n;
        n = wr_cnt;
        u_host.frame(cal_cmd(1'b0, 3'h3, 1'b0), 24'hFFFFFF, 12, rdata);
        chk(wr_cnt, n);
        u_host.frame(cal_cmd(1'b0, 3'h3, 1'b0), 24'h123456, 24, rdata);
        chk(wr_cnt, n + 1);
        chk(last_wr, 24'h123456);
    endtask : t_abort
    // the two-channel variant refuses gain register 3 and offset register 8
    task automatic t_reject;
        int n;
        int a;
        n = rej_small_cnt;
        a = acc_small_cnt;
        u_host.frame(cal_cmd(1'b1, 3'h2, 1'b1), 24'h000000, 24, rdata);
        chk(rej_small_cnt, n + 1);
        u_host.frame(cal_cmd(1'b0, 3'h7, 1'b0), 24'h00BEEF, 24, rdata);
        chk(rej_small_cnt, n + 2);
        chk(acc_small_cnt, a);
        chk(last_wr, 24'h00BEEF);
    endtask : t_reject
    ////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    initial begin
        #1_000_000;
        failures++;
        results();
    end
    initial begin
        srst = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        srst = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        chk({wr_stb, rd_req, pass_stb, rej_stb, sel_gain, sel_chan, cmd_byte}, 0);
        t_write_read(1'b0);
        t_write_read(1'b1);
        t_pass();
        t_abort();
        t_reject();
        chk(rej_cnt, 0);
        results();
    end
endmodule : testbench
